/* File: src/irq_ctl_map.svh */
// Purpose: offsets, field positions, reset values of the irq controller
// Assumes: word-aligned byte offsets on the plain register port
// Notes: definitions only
//
// How it works
// RULE1: dispatch-select one gives per-source vectors; zero sends all through one.
// RULE2: threshold n (2..7) starts timer for priority n or lower; 1 only one.
// RULE3: threshold zero keeps the proximity timer disabled, never started.
// RULE4: each of five external inputs has polarity: one rising, zero falling.
// RULE5: status bits 10..8 hold priority level of latest presented interrupt.
// RULE6: status bits 5..0 hold interrupt number presented to the core.
// RULE7: software trusts status level and number only in single-vector dispatch.
// RULE8: qualifying event loads the proximity timer from the reload register; the code loads it only from idle, not while it runs.
// RULE9: unimplemented control and status bits read as zero.
// RULE10: timer counts down per clock; qualifying interrupts held until zero.
`ifndef IRQ_CTL_MAP_SVH
`define IRQ_CTL_MAP_SVH

`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RELOAD 8'h08
`define OFS_EVT_STAT 8'h0c
`define OFS_EVT_MASK 8'h10

`define CTL_MULTI_DISPATCH_SELECT_BIT 12
`define CTL_THR_LSB 8
`define CTL_EDGE_LSB 0
`define STAT_PRIO_LSB 8
`define STAT_NUM_LSB 0

`define RESET_WORD 32'h0000_0000
`define RESET_THR 3'h0
`define RESET_EDGE 5'h00
`define SINGLE_VEC 6'h00
`define EXT_COUNT 5
`define EVT_COUNT 3
`define TIMER_DEC 32'h0000_0001

`endif

/* File: src/irq_ctl_pkg.sv */
// Purpose: types shared by the irq controller modules
// Assumes: nothing
// Notes: constants live in irq_ctl_map.svh
package irq_ctl_pkg;
  typedef enum logic [1:0] {
    PROX_IDLE = 2'b00,
    PROX_RUN = 2'b01
  } prox_state_t;
  typedef logic [5:0] irq_num_t;
  typedef logic [2:0] irq_prio_t;
  typedef logic [4:0] ext_vec_t;
endpackage : irq_ctl_pkg

/* File: src/ext_edge_if.sv */
// Purpose: carrier between the controller and its edge detector
// Assumes: one clock domain
// Notes: pins and polarity in, one-cycle edge events out
`timescale 1ns/10ps
`default_nettype none
interface ext_edge_if;
  import irq_ctl_pkg::*;
  ext_vec_t pins;
  ext_vec_t edge_sel;
  ext_vec_t edge_evt;
  modport det (input pins, input edge_sel, output edge_evt);
  modport ctl (output pins, output edge_sel, input edge_evt);
endinterface : ext_edge_if
`default_nettype wire

/* File: src/ext_edge_detect.sv */
// Purpose: edge detector for the five external interrupt inputs
// Assumes: inputs synchronous to i_clk
// Notes: event is a one-cycle pulse, combinational from the last sample
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctl_map.svh"
module ext_edge_detect import irq_ctl_pkg::*; (
  input wire logic i_clk,
  input wire logic i_srst,
  ext_edge_if.det bus
);
  ext_vec_t prev_r;
  ext_vec_t prev_nxt;
  ext_vec_t evt;

  always_comb begin
    prev_nxt = bus.pins;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev_r <= `RESET_EDGE;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // first sample after reset sees prev = 0, so a high pin may read as rising
  for (genvar g = 0; g < `EXT_COUNT; g++) begin : g_edge
    always_comb begin
      if (bus.edge_sel[g]) begin
        evt[g] = bus.pins[g] & ~prev_r[g]; // [RULE4]
      end else begin
        evt[g] = ~bus.pins[g] & prev_r[g]; // [RULE4]
      end
    end
  end

  assign bus.edge_evt = evt;
endmodule : ext_edge_detect
`default_nettype wire

/* File: src/irq_controller_config.sv */
// Purpose: irq controller configuration, status and proximity timer
// Assumes: single clock, plain register port, core acks presented irq
// Notes: five external sources, irq number equals source index
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctl_map.svh"
module irq_controller_config import irq_ctl_pkg::*; (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [4:0] i_ext_irq,
  input wire logic [14:0] i_ext_prio,
  input wire logic i_core_ack,
  output logic o_core_req,
  output logic [5:0] o_core_vec,
  output logic [2:0] o_core_prio,
  output logic o_irq
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic qualifies(input irq_prio_t p,
                                     input irq_prio_t thr);
    // priority 0 never qualifies, so code 1 admits priority 1 only
    qualifies = (thr != 3'h0) && (p != 3'h0) && (p <= thr); // [RULE2] [RULE3]
  endfunction : qualifies

  // ****************************************
  // state
  // ****************************************
  logic multi_dispatch_select_r, multi_dispatch_select_nxt;
  irq_prio_t proximity_threshold_sel_r, proximity_threshold_sel_nxt;
  ext_vec_t edge_sel_r, edge_sel_nxt;
  logic [31:0] proximity_reload_value_r, proximity_reload_value_nxt;
  logic [`EVT_COUNT-1:0] evt_stat_r, evt_stat_nxt;
  logic [`EVT_COUNT-1:0] evt_mask_r, evt_mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;

  ext_vec_t pending_r, pending_nxt;
  prox_state_t prox_state_r, prox_state_nxt;
  logic [31:0] prox_cnt_r, prox_cnt_nxt;
  logic req_r, req_nxt;
  irq_num_t vec_r, vec_nxt;
  irq_prio_t prio_r, prio_nxt;
  irq_num_t presented_irq_number_r, presented_irq_number_nxt;
  irq_prio_t presented_priority_level_r, presented_priority_level_nxt;
  logic [2:0] sel_idx_r, sel_idx_nxt;

  // ****************************************
  // external edge detection
  // ****************************************
  ext_edge_if edge_bus ();
  assign edge_bus.pins = i_ext_irq;
  assign edge_bus.edge_sel = edge_sel_r;

  ext_edge_detect u_edge (
    .i_clk (i_clk),
    .i_srst (i_srst),
    .bus (edge_bus.det)
  );

  irq_prio_t src_prio [`EXT_COUNT];
  ext_vec_t qual;
  for (genvar g = 0; g < `EXT_COUNT; g++) begin : g_src
    assign src_prio[g] = i_ext_prio[3*g +: 3];
    assign qual[g] = qualifies(src_prio[g], proximity_threshold_sel_r);
  end

  // ****************************************
  // proximity timer and pending
  // ****************************************
  ext_vec_t ack_clear;
  logic prox_expire;
  logic prox_run;

  always_comb begin
    ack_clear = '0;
    if (i_core_ack && req_r) begin
      ack_clear[sel_idx_r] = 1'b1;
    end
    // set wins over the ack clear
    pending_nxt = (pending_r & ~ack_clear) | edge_bus.edge_evt;
    prox_state_nxt = prox_state_r;
    prox_cnt_nxt = prox_cnt_r;
    prox_expire = 1'b0;
    unique case (prox_state_r)
      PROX_IDLE: begin
        if (|(edge_bus.edge_evt & qual)) begin
          prox_cnt_nxt = proximity_reload_value_r; // [RULE8]
          prox_state_nxt = PROX_RUN;
        end
      end
      PROX_RUN: begin
        if (proximity_threshold_sel_r == 3'h0) begin
          prox_state_nxt = PROX_IDLE; // [RULE3]
        end else if (prox_cnt_r == 32'h0000_0000) begin
          prox_state_nxt = PROX_IDLE; // [RULE10]
          prox_expire = 1'b1;
        end else begin
          prox_cnt_nxt = prox_cnt_r - `TIMER_DEC; // [RULE10]
        end
      end
      default: begin
        prox_state_nxt = PROX_IDLE;
      end
    endcase
  end

  assign prox_run = (prox_state_r == PROX_RUN);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pending_r <= `RESET_EDGE;
      prox_state_r <= PROX_IDLE;
      prox_cnt_r <= `RESET_WORD;
    end else begin
      pending_r <= pending_nxt;
      prox_state_r <= prox_state_nxt;
      prox_cnt_r <= prox_cnt_nxt;
    end
  end

  // ****************************************
  // presentation to the core
  // ****************************************
  ext_vec_t eligible;
  logic found;
  logic [2:0] best_idx;
  irq_prio_t best_prio;
  logic new_present;

  always_comb begin
    // qualifying sources wait while the timer runs, then go together
    eligible = pending_r & ~(qual & {`EXT_COUNT{prox_run}}); // [RULE10]
    found = 1'b0;
    best_idx = 3'h0;
    best_prio = 3'h0;
    for (int i = 0; i < `EXT_COUNT; i++) begin
      if (eligible[i] && (!found || src_prio[i] > best_prio)) begin
        found = 1'b1;
        best_idx = 3'(i);
        best_prio = src_prio[i];
      end
    end
    if (ack_clear[best_idx]) begin
      found = 1'b0;
    end
    req_nxt = found;
    sel_idx_nxt = found ? best_idx : sel_idx_r;
    prio_nxt = found ? best_prio : prio_r;
    if (!found) begin
      vec_nxt = vec_r;
    end else if (multi_dispatch_select_r) begin
      vec_nxt = irq_num_t'(best_idx); // [RULE1]
    end else begin
      vec_nxt = `SINGLE_VEC; // [RULE1]
    end
    new_present = found && (!req_r || best_idx != sel_idx_r);
    presented_irq_number_nxt = found ? irq_num_t'(best_idx) :
                               presented_irq_number_r; // [RULE6]
    presented_priority_level_nxt = found ? best_prio :
                                   presented_priority_level_r; // [RULE5]
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      req_r <= 1'b0;
      sel_idx_r <= 3'h0;
      prio_r <= 3'h0;
      vec_r <= `SINGLE_VEC;
      presented_irq_number_r <= `SINGLE_VEC;
      presented_priority_level_r <= 3'h0;
    end else begin
      req_r <= req_nxt;
      sel_idx_r <= sel_idx_nxt;
      prio_r <= prio_nxt;
      vec_r <= vec_nxt;
      presented_irq_number_r <= presented_irq_number_nxt;
      presented_priority_level_r <= presented_priority_level_nxt;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  logic [`EVT_COUNT-1:0] evt_set;
  logic [`EVT_COUNT-1:0] evt_clr;

  always_comb begin
    multi_dispatch_select_nxt = multi_dispatch_select_r;
    proximity_threshold_sel_nxt = proximity_threshold_sel_r;
    edge_sel_nxt = edge_sel_r;
    proximity_reload_value_nxt = proximity_reload_value_r;
    evt_mask_nxt = evt_mask_r;
    evt_clr = '0;
    // status fields are hardware owned, so writes to them fall away
    if (i_wr) begin
      if (hit(i_addr, `OFS_CONTROL)) begin
        multi_dispatch_select_nxt = i_wdata[`CTL_MULTI_DISPATCH_SELECT_BIT];
        proximity_threshold_sel_nxt = i_wdata[`CTL_THR_LSB +: 3];
        edge_sel_nxt = i_wdata[`CTL_EDGE_LSB +: `EXT_COUNT]; // [RULE4]
      end
      if (hit(i_addr, `OFS_RELOAD)) begin
        proximity_reload_value_nxt = i_wdata;
      end
      // write one to clear
      if (hit(i_addr, `OFS_EVT_STAT)) begin
        evt_clr = i_wdata[`EVT_COUNT-1:0];
      end
      if (hit(i_addr, `OFS_EVT_MASK)) begin
        evt_mask_nxt = i_wdata[`EVT_COUNT-1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      multi_dispatch_select_r <= 1'b0;
      proximity_threshold_sel_r <= `RESET_THR;
      edge_sel_r <= `RESET_EDGE;
      proximity_reload_value_r <= `RESET_WORD;
      evt_mask_r <= '0;
    end else begin
      multi_dispatch_select_r <= multi_dispatch_select_nxt;
      proximity_threshold_sel_r <= proximity_threshold_sel_nxt;
      edge_sel_r <= edge_sel_nxt;
      proximity_reload_value_r <= proximity_reload_value_nxt;
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // ****************************************
  // event status and interrupt
  // ****************************************
  always_comb begin
    // bit0 external edge, bit1 timer expiry, bit2 new presentation
    evt_set = {new_present, prox_expire, |edge_bus.edge_evt};
    // set wins over the clear, so an event in the clear cycle survives
    evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;
    // next status and mask, so a clear drops the line at the same edge as the status bit
    irq_nxt = |(evt_stat_nxt & evt_mask_nxt);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      evt_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      evt_stat_r <= evt_stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    // zero outside the read cycle, so the port can be or-ed with others
    rdata_nxt = `RESET_WORD;
    // unmapped addresses match no branch and read as zero
    if (i_rd) begin
      if (hit(i_addr, `OFS_CONTROL)) begin
        rdata_nxt[`CTL_MULTI_DISPATCH_SELECT_BIT] = multi_dispatch_select_r; // [RULE9]
        rdata_nxt[`CTL_THR_LSB +: 3] = proximity_threshold_sel_r;
        rdata_nxt[`CTL_EDGE_LSB +: `EXT_COUNT] = edge_sel_r;
      end else if (hit(i_addr, `OFS_STATUS)) begin
        // valid for software only in single-vector dispatch
        rdata_nxt[`STAT_PRIO_LSB +: 3] =
          presented_priority_level_r; // [RULE5] [RULE7] [RULE9]
        rdata_nxt[`STAT_NUM_LSB +: 6] = presented_irq_number_r; // [RULE6]
      end else if (hit(i_addr, `OFS_RELOAD)) begin
        rdata_nxt = proximity_reload_value_r;
      end else if (hit(i_addr, `OFS_EVT_STAT)) begin
        rdata_nxt[`EVT_COUNT-1:0] = evt_stat_r;
      end else if (hit(i_addr, `OFS_EVT_MASK)) begin
        rdata_nxt[`EVT_COUNT-1:0] = evt_mask_r;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_r <= `RESET_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_core_req = req_r;
  assign o_core_vec = vec_r;
  assign o_core_prio = prio_r;
  assign o_irq = irq_r;
endmodule : irq_controller_config
`default_nettype wire

/* File: verif/irq_cfg_props.sv */
// Purpose: port checks for irq_controller_config
// Assumes: bound to the top module, one clock
// Notes: shadows control and reload to judge read-back
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctl_map.svh"
module irq_cfg_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_core_req,
  input wire logic [5:0] o_core_vec,
  input wire logic [2:0] o_core_prio,
  input wire logic o_irq
);
  // ***
  // shadows and properties
  // ***
  logic [31:0] ctl_r;
  logic [31:0] ctl_nxt;
  logic [31:0] rel_r;
  logic [31:0] rel_nxt;
  always_comb begin
    ctl_nxt = ctl_r;
    rel_nxt = rel_r;
    if (i_wr && i_addr == `OFS_CONTROL) ctl_nxt = i_wdata & 32'h0000_171f;
    if (i_wr && i_addr == `OFS_RELOAD) rel_nxt = i_wdata;
  end
  always_ff @(posedge i_clk) begin
    ctl_r <= i_srst ? 32'h0000_0000 : ctl_nxt;
    rel_r <= i_srst ? 32'h0000_0000 : rel_nxt;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // status read while one presentation holds steady
  sequence s_steady_rd;
    o_core_req && $past(o_core_req) && $stable(o_core_prio) &&
      $stable(o_core_vec) && i_rd && i_addr == `OFS_STATUS;
  endsequence
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_ctl_rw;
    $past(i_rd && i_addr == `OFS_CONTROL) |-> o_rdata == $past(ctl_r);
  endproperty
  a_ctl_rw: assert property (p_ctl_rw) else $error("control readback");
  property p_rel_rw;
    $past(i_rd && i_addr == `OFS_RELOAD) |-> o_rdata == $past(rel_r);
  endproperty
  a_rel_rw: assert property (p_rel_rw) else $error("reload readback");
  property p_stat_pad;
    $past(i_rd && i_addr == `OFS_STATUS) |->
      o_rdata[31:11] == 21'h00_0000 && o_rdata[7:6] == 2'h0;
  endproperty
  a_stat_pad: assert property (p_stat_pad) else $error("status pad");
  property p_single_vec;
    o_core_req && !ctl_r[12] && !$past(ctl_r[12]) |-> o_core_vec == 6'h00;
  endproperty
  a_single_vec: assert property (p_single_vec) else $error("single vec");
  property p_vec_range; o_core_req |-> o_core_vec < 6'h05; endproperty
  a_vec_range: assert property (p_vec_range) else $error("vec range");
  property p_irq_fall;
    $fell(o_irq) |-> $past(i_wr) &&
      ($past(i_addr) == `OFS_EVT_STAT || $past(i_addr) == `OFS_EVT_MASK);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_stat_prio;
    s_steady_rd |=> o_rdata[10:8] == $past(o_core_prio) &&
      (!ctl_r[12] || o_rdata[5:0] == $past(o_core_vec));
  endproperty
  a_stat_prio: assert property (p_stat_prio) else $error("status");
endmodule : irq_cfg_props
`default_nettype wire

/* File: verif/core_model.sv */
// Purpose: behavioural core taking presented interrupts
// Assumes: request updates one edge after an ack pulse
// Notes: i_delay keeps a request standing longer
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_req,
  input wire logic [5:0] i_vec,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [5:0] o_vec,
  output logic [7:0] o_cnt
);
  logic [4:0] wait_r;
  // one idle edge after ack so a stale request is not taken twice
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ack <= 1'b0;
      o_vec <= 6'h00;
      o_cnt <= 8'h00;
      wait_r <= 5'h00;
    end else if (o_ack) begin
      o_ack <= 1'b0;
    end else if (!i_req) begin
      wait_r <= 5'h00;
    end else if (wait_r > {1'b0, i_delay}) begin
      o_ack <= 1'b1;
      o_vec <= i_vec;
      o_cnt <= o_cnt + 8'h01;
      wait_r <= 5'h00;
    end else begin
      wait_r <= wait_r + 5'h01;
    end
  end
endmodule : core_model
`default_nettype wire

/* File: verif/irq_controller_config_tb_top.sv */
// Purpose: register, dispatch and proximity tests
// Assumes: core_model answers presented requests
// Notes: short reload keeps hold windows brief
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctl_map.svh"
module irq_controller_config_tb_top;
  localparam int R = 10;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [4:0] pins = 5'h00;
  logic [3:0] dly = 4'h0;
  logic [31:0] rdata;
  logic ack;
  logic req;
  logic irq;
  logic [5:0] vec;
  logic [5:0] cvec;
  logic [2:0] cprio;
  logic [7:0] cnt;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  // ***
  // instances, source g at priority g+1
  // ***
  irq_controller_config irq_controller_config_inst (
    .i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_ext_irq(pins),
    .i_ext_prio(15'h58d1), .i_core_ack(ack), .o_core_req(req),
    .o_core_vec(vec), .o_core_prio(cprio), .o_irq(irq));
  core_model core_model_inst (
    .i_clk(clk), .i_srst(srst), .i_req(req), .i_vec(vec),
    .i_delay(dly), .o_ack(ack), .o_vec(cvec), .o_cnt(cnt));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
  endtask : rd
  task automatic chk_irq(input logic e);
    #1;
    check({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask : chk_irq
  // inactive-direction move first, so only the final move is an edge
  task automatic fire(input int g, input logic act);
    pins[g] <= ~act;
    tick(3);
    pins[g] <= act;
  endtask : fire
  task automatic present(input logic held, input logic [5:0] v);
    logic [7:0] c0;
    int n;
    c0 = cnt;
    n = 0;
    while (cnt === c0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check({30'h0, n < R + 12, n > R}, {30'h0, 1'b1, held});
    check({26'h0, cvec}, {26'h0, v});
    tick(2);
  endtask : present
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] c0;
    int s;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    tick(2);
    for (int a = 0; a < 6; a++) rd(8'(4 * a), 32'h0000_0000);
    wr(`OFS_CONTROL, 32'hffff_ffff);
    rd(`OFS_CONTROL, 32'h0000_171f);
    wr(`OFS_STATUS, 32'hffff_ffff);
    wr(8'h14, 32'hffff_ffff);
    rd(`OFS_STATUS, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    wr(`OFS_RELOAD, 32'ha5a5_5a5a);
    rd(`OFS_RELOAD, 32'ha5a5_5a5a);
    wr(`OFS_RELOAD, 32'(R));
    $display("test registers done");
    for (int g = 0; g < 5; g++) begin
      wr(`OFS_CONTROL, 32'h0000_1000 | (32'h0000_0001 << g));
      fire(g, 1'b1);
      present(1'b0, 6'(g));
      c0 = cnt;
      fire(g, 1'b0);
      tick(8);
      check({24'h00_0000, cnt}, {24'h00_0000, c0});
    end
    wr(`OFS_CONTROL, 32'h0000_0000);
    dly <= 4'h6;
    fire(2, 1'b0);
    tick(4);
    rd(`OFS_STATUS, 32'h0000_0302);
    present(1'b0, 6'h00);
    dly <= 4'h0;
    $display("test dispatch done");
    for (int k = 0; k < 8; k++) begin
      s = (k == 0) ? 0 : ((k > 5) ? 4 : k - 1);
      wr(`OFS_CONTROL, 32'h0000_1000 | (32'(k) << 8));
      fire(s, 1'b0);
      present(k != 0, 6'(s));
      if (k < 5) begin
        fire(k, 1'b0);
        present(1'b0, 6'(k));
      end
    end
    $display("test proximity done");
    wr(`OFS_EVT_MASK, 32'h0000_0002);
    wr(`OFS_EVT_STAT, 32'h0000_0007);
    rd(`OFS_EVT_STAT, 32'h0000_0000);
    chk_irq(1'b0);
    fire(3, 1'b0);
    present(1'b1, 6'h03);
    chk_irq(1'b1);
    rd(`OFS_EVT_STAT, 32'h0000_0007);
    wr(`OFS_EVT_STAT, 32'h0000_0002);
    chk_irq(1'b0);
    rd(`OFS_EVT_STAT, 32'h0000_0005);
    rd(`OFS_EVT_MASK, 32'h0000_0002);
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule : irq_controller_config_tb_top
bind irq_controller_config irq_cfg_props irq_cfg_props_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_core_req(o_core_req),
  .o_core_vec(o_core_vec), .o_core_prio(o_core_prio), .o_irq(o_irq));
`default_nettype wire
